// ### verif/async_serial_port_flow_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_errors++; \
  $display("[ERR] %s expected %h seen %h", nm, e, s); end end
module async_serial_port_flow_ctrl_tb_top
  import serial_port_pkg::*;
;
  localparam logic [DIV_W-1:0] DIV = 16'h0008;
  logic                 mclk      = 1'b0;
  logic                 srst      = 1'b1;
  logic                 par_en    = 1'b0;
  logic                 par_odd   = 1'b0;
  logic                 cts_float = 1'b0;
  logic                 rx_float  = 1'b0;
  logic [1:0]           hold      = 2'b00;
  logic [1:0]           tx_valid  = 2'b00;
  logic [1:0]           rx_ready  = 2'b00;
  logic [1:0]           tx_ready, rx_valid, rx_perr, rx_ferr;
  logic [DATA_BITS-1:0] tx_data [2] = '{8'h00, 8'h00};
  logic [DATA_BITS-1:0] rx_data [2];
  logic [DATA_BITS-1:0] exp_q [2][$];
  logic [31:0]          seed      = 32'h0000A83F;
  int                   n_errors  = 0;
  int                   checks    = 0;
  serial_link_if lnk ();
  always #5 mclk = ~mclk;
  serial_device_end serial_device_end_i (.mclk, .srst, .link(lnk), .rx_floating(rx_float),
    .cts_floating(cts_float), .bit_div(DIV), .parity_en(par_en), .parity_odd(par_odd),
    .tx_valid(tx_valid[0]), .tx_ready(tx_ready[0]), .tx_data(tx_data[0]),
    .rx_valid(rx_valid[0]), .rx_ready(rx_ready[0]), .rx_data(rx_data[0]),
    .rx_parity_err(rx_perr[0]), .rx_frame_err(rx_ferr[0]));
  serial_host_end serial_host_end_i (.mclk, .srst, .link(lnk), .bit_div(DIV),
    .parity_en(par_en), .parity_odd(par_odd),
    .tx_valid(tx_valid[1]), .tx_ready(tx_ready[1]), .tx_data(tx_data[1]),
    .rx_valid(rx_valid[1]), .rx_ready(rx_ready[1]), .rx_data(rx_data[1]),
    .rx_parity_err(rx_perr[1]), .rx_frame_err(rx_ferr[1]));
  serial_link_properties #(.DIV(8)) serial_link_properties_i (.mclk, .srst,
    .general_pin_six(lnk.general_pin_six), .general_pin_eight(lnk.general_pin_eight),
    .general_pin_five(lnk.general_pin_five), .general_pin_seven(lnk.general_pin_seven),
    .cts_floating(cts_float));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ****************
  // Drivers and monitor
  // ****************
  // Sender i fills the queue of the opposite receiver
  task automatic send(input int i, input int n);
    int t;
    for (int k = 0; k < n; k++) begin
      @(negedge mclk);
      tx_data[i] = 8'(rnd());
      tx_valid[i] = 1'b1;
      t = 0;
      do begin
        @(posedge mclk);
        t++;
      end while (tx_ready[i] !== 1'b1 && t < 5000);
      if (t >= 5000) begin
        n_errors++;
        stop_test();
      end
      exp_q[1-i].push_back(tx_data[i]);
      @(negedge mclk) tx_valid[i] = 1'b0;
    end
  endtask
  task automatic drain();
    int t;
    t = 0;
    while (exp_q[0].size() + exp_q[1].size() != 0 && t < 20000) begin
      @(posedge mclk);
      t++;
    end
    if (t >= 20000) begin
      n_errors++;
      stop_test();
    end
  endtask
  always @(negedge mclk) rx_ready <= ~hold & 2'(rnd() >> 30);
  always @(posedge mclk) begin
    logic [DATA_BITS-1:0] want;
    for (int i = 0; i < 2; i++) begin
      if (!srst && rx_valid[i] === 1'b1 && rx_ready[i]) begin
        want = (exp_q[i].size() != 0) ? exp_q[i].pop_front() : ~rx_data[i];
        `CHK("rx data", want, rx_data[i])
        `CHK("parity err", 1'b0, rx_perr[i])
        `CHK("frame err", 1'b0, rx_ferr[i])
      end
    end
  end
  initial begin
    repeat (16) @(posedge mclk);
    @(negedge mclk) srst = 1'b0;
    repeat (4) @(negedge mclk);
    `CHK("request idle", HS_ASSERT, lnk.general_pin_five)
    for (int m = 0; m < 3; m++) begin
      @(negedge mclk);
      par_en = (m != 0);
      par_odd = (m == 2);
      hold = (m == 1) ? 2'b01 : 2'b00;
      fork
        send(0, 6);
        send(1, 6);
        begin
          repeat (2000) @(negedge mclk);
          if (m == 1) `CHK("request stall", HS_DEASSERT, lnk.general_pin_five)
          hold = 2'b00;
        end
      join
      drain();
    end
    // Open clear pin must let the device send past a stalled host
    @(negedge mclk) hold = 2'b10;
    send(0, 1);
    repeat (200) @(negedge mclk);
    `CHK("clear held off", HS_DEASSERT, lnk.general_pin_seven)
    cts_float = 1'b1;
    send(0, 1);
    cts_float = 1'b0;
    hold = 2'b00;
    drain();
    // Open receive pin reads idle, so a host word never arrives
    @(negedge mclk) rx_float = 1'b1;
    send(1, 1);
    void'(exp_q[0].pop_back());
    repeat (120) @(negedge mclk);
    `CHK("open rx idle", 1'b0, rx_valid[0])
    rx_float = 1'b0;
    stop_test();
  end
endmodule
`default_nettype wire

// ### verif/serial_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module serial_link_properties
  import serial_port_pkg::*;
#(
  parameter int unsigned DIV = 8
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic general_pin_six,
  input wire logic general_pin_eight,
  input wire logic general_pin_five,
  input wire logic general_pin_seven,
  input wire logic cts_floating
);
  // ****************
  // Frame tracking
  // ****************
  // A fall counts as a start only past data and parity, so data edges are skipped
  localparam int unsigned FRAME = 10 * DIV;
  logic [1:0]  ln;
  logic [1:0]  ln_q;
  logic [1:0]  start;
  int unsigned cnt [2];
  assign ln       = {general_pin_eight, general_pin_six};
  assign start[0] = ln_q[0] & ~ln[0] & (cnt[0] >= FRAME);
  assign start[1] = ln_q[1] & ~ln[1] & (cnt[1] >= FRAME);
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 2; i++) begin
      if (srst) begin
        ln_q[i] <= 1'b1;
        cnt[i]  <= FRAME;
      end else begin
        ln_q[i] <= ln[i];
        cnt[i]  <= start[i] ? 1 : ((cnt[i] < FRAME) ? cnt[i] + 1 : cnt[i]);
      end
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // ****************
  // Link checks, bit period fixed at 8
  // ****************
  chk_reset_idle: assert property ($fell(srst) |-> general_pin_six && general_pin_eight
    && general_pin_five && general_pin_seven) else $error("lines not high at reset exit");
  chk_request_on: assert property ($fell(srst) |-> ##[1:3] (general_pin_five == HS_ASSERT
    && general_pin_seven == HS_ASSERT)) else $error("request not asserted");
  chk_dev_bit_len: assert property ($fell(general_pin_six) |-> (!general_pin_six)[*8])
    else $error("device low bit too short");
  chk_host_bit_len: assert property ($fell(general_pin_eight) |-> (!general_pin_eight)[*8])
    else $error("host low bit too short");
  // An open clear pin reads asserted, so it also permits a start
  chk_dev_waits_clear: assert property (start[0] |-> (!$past(general_pin_seven, 2)
    || !$past(general_pin_seven, 3) || $past(cts_floating, 3)))
    else $error("device sent while clear high");
  chk_host_obeys_request: assert property (start[1] |-> (!$past(general_pin_five, 2)
    || !$past(general_pin_five, 3))) else $error("host sent while request high");
  chk_dev_stop_len: assert property (start[0] |-> $past(general_pin_six, 8))
    else $error("device stop too short");
  chk_host_stop_len: assert property (start[1] |-> $past(general_pin_eight, 8))
    else $error("host stop too short");
endmodule
`default_nettype wire

// ### verilog/serial_device_end.sv
`timescale 1ns/1ps
`default_nettype none
// ******************************
// Notes on behaviour
// ******************************
// Notes on behaviour
// - Full-duplex serial with flow control, 1 Mbps
// - Optional parity as ninth bit, checked
// - Handshake lines active low
// - Drive request, sample clear before sending
// - Data lines idle high once configured
// - Request asserted low after configuration
// - Receive input pulled up when open
// - Clear input pulled down when open
// - Host sends on receive, takes transmit
// - Host stops while request deasserted
// - One port instance; this module instantiates a single serial_engine
module serial_device_end
  import serial_port_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 srst,
  serial_link_if.device             link,
  input  wire logic                 rx_floating,
  input  wire logic                 cts_floating,
  input  wire logic [DIV_W-1:0]     bit_div,
  input  wire logic                 parity_en,
  input  wire logic                 parity_odd,
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  input  wire logic [DATA_BITS-1:0] tx_data,
  output logic                      rx_valid,
  input  wire logic                 rx_ready,
  output logic [DATA_BITS-1:0]      rx_data,
  output logic                      rx_parity_err,
  output logic                      rx_frame_err
);
  // ******************************
  // Pin conditioning
  // ******************************
  wire rx_in  = rx_floating  ? IDLE_LEVEL : link.general_pin_eight;
  wire cts_in = cts_floating ? HS_ASSERT  : link.general_pin_seven;
  logic cts_q;
  logic space;
  logic rts;
  always_ff @(posedge mclk) begin
    if (srst) begin
      cts_q <= HS_DEASSERT;
      rts   <= HS_DEASSERT;
    end else begin
      cts_q <= cts_in;
      rts   <= space ? HS_ASSERT : HS_DEASSERT;
    end
  end
  assign link.general_pin_five = rts;

  // ******************************
  // Engine
  // ******************************
  serial_engine u_engine (
    .mclk          (mclk),
    .srst          (srst),
    .bit_div       (bit_div),
    .parity_en     (parity_en),
    .parity_odd    (parity_odd),
    .tx_allowed    (cts_q == HS_ASSERT),
    .tx_valid      (tx_valid),
    .tx_ready      (tx_ready),
    .tx_data       (tx_data),
    .tx_line       (link.general_pin_six),
    .rx_line       (rx_in),
    .rx_valid      (rx_valid),
    .rx_ready      (rx_ready),
    .rx_data       (rx_data),
    .rx_parity_err (rx_parity_err),
    .rx_frame_err  (rx_frame_err),
    .buf_space     (space)
  );
endmodule
`default_nettype wire

// ### verilog/serial_engine.sv
`timescale 1ns/1ps
`default_nettype none
// Shared transmitter, receiver and two-entry receive buffer for one end
module serial_engine
  import serial_port_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 srst,
  input  wire logic [DIV_W-1:0]     bit_div,
  input  wire logic                 parity_en,
  input  wire logic                 parity_odd,
  input  wire logic                 tx_allowed,
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  input  wire logic [DATA_BITS-1:0] tx_data,
  output logic                      tx_line,
  input  wire logic                 rx_line,
  output logic                      rx_valid,
  input  wire logic                 rx_ready,
  output logic [DATA_BITS-1:0]      rx_data,
  output logic                      rx_parity_err,
  output logic                      rx_frame_err,
  output logic                      buf_space
);
  // ******************************
  // Transmitter
  // ******************************
  frame_state_t             tx_state;
  logic [DIV_W-1:0]         tx_tick;
  logic [CNT_W-1:0]         tx_bit;
  logic [DATA_BITS-1:0]     tx_shift;
  logic                     tx_par;
  wire                      tx_tick_end = (tx_tick == bit_div - DIV_W'(1));
  // Ready is a flop, so a handshake change gates a new word one cycle later
  wire                      tx_take     = tx_valid && tx_ready;
  wire                      next_tx_idle = ((tx_state == ST_IDLE) && !tx_take)
                                        || ((tx_state == ST_STOP) && tx_tick_end);

  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_state <= ST_IDLE;
      tx_tick  <= '0;
      tx_bit   <= '0;
      tx_shift <= '0;
      tx_par   <= 1'b0;
      tx_line  <= IDLE_LEVEL;
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= next_tx_idle && tx_allowed;
      tx_tick <= (tx_state == ST_IDLE || tx_tick_end) ? '0 : tx_tick + DIV_W'(1);
      unique case (tx_state)
        ST_IDLE: begin
          tx_line <= IDLE_LEVEL;
          if (tx_take) begin
            tx_state <= ST_START;
            tx_shift <= tx_data;
            tx_par   <= parity_of(tx_data, parity_odd);
            tx_line  <= START_LEVEL;
          end
        end
        ST_START: if (tx_tick_end) begin
          tx_state <= ST_DATA;
          tx_bit   <= '0;
          tx_line  <= tx_shift[0];
        end
        ST_DATA: if (tx_tick_end) begin
          tx_shift <= tx_shift >> 1;
          tx_bit   <= tx_bit + CNT_W'(1);
          if (tx_bit == LAST_DATA) begin
            tx_state <= parity_en ? ST_PARITY : ST_STOP;
            tx_line  <= parity_en ? tx_par : STOP_LEVEL;
          end else begin
            tx_line <= tx_shift[1];
          end
        end
        ST_PARITY: if (tx_tick_end) begin
          tx_state <= ST_STOP;
          tx_line  <= STOP_LEVEL;
        end
        ST_STOP: if (tx_tick_end) begin
          tx_state <= ST_IDLE;
        end
      endcase
    end
  end

  // ******************************
  // Receiver
  // ******************************
  frame_state_t             rx_state;
  logic [DIV_W-1:0]         rx_tick;
  logic [CNT_W-1:0]         rx_bit;
  logic [DATA_BITS-1:0]     rx_shift;
  logic                     rx_par;
  logic                     rx_push;
  logic                     rx_push_perr;
  logic                     rx_push_ferr;
  // Sample mid-bit; start is sampled at half a bit to reject glitches
  wire rx_half = (rx_tick == (bit_div >> 1));
  wire rx_full = (rx_tick == bit_div - DIV_W'(1));
  wire rx_samp = (rx_state == ST_START) ? rx_half : rx_full;

  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_state     <= ST_IDLE;
      rx_tick      <= '0;
      rx_bit       <= '0;
      rx_shift     <= '0;
      rx_par       <= 1'b0;
      rx_push      <= 1'b0;
      rx_push_perr <= 1'b0;
      rx_push_ferr <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      rx_tick <= (rx_state == ST_IDLE || rx_samp) ? '0 : rx_tick + DIV_W'(1);
      unique case (rx_state)
        ST_IDLE: if (rx_line == START_LEVEL) rx_state <= ST_START;
        ST_START: if (rx_samp) begin
          rx_state <= (rx_line == START_LEVEL) ? ST_DATA : ST_IDLE;
          rx_bit   <= '0;
        end
        ST_DATA: if (rx_samp) begin
          rx_shift <= {rx_line, rx_shift[DATA_BITS-1:1]};
          rx_bit   <= rx_bit + CNT_W'(1);
          if (rx_bit == LAST_DATA) rx_state <= parity_en ? ST_PARITY : ST_STOP;
        end
        ST_PARITY: if (rx_samp) begin
          rx_par   <= rx_line;
          rx_state <= ST_STOP;
        end
        ST_STOP: if (rx_samp) begin
          rx_state     <= ST_IDLE;
          rx_push      <= 1'b1;
          rx_push_perr <= parity_en && (rx_par != parity_of(rx_shift, parity_odd));
          rx_push_ferr <= (rx_line != STOP_LEVEL);
        end
      endcase
    end
  end

  // ******************************
  // Two-entry receive buffer
  // ******************************
  // Overflow drops the new word; the handshake is meant to prevent it
  localparam int unsigned EW = DATA_BITS + 2;
  logic [EW-1:0] slot [BUF_DEPTH];
  logic          rd_ptr;
  logic          wr_ptr;
  logic [1:0]    count;
  wire           buf_full  = (count == 2'(BUF_DEPTH));
  wire           do_write  = rx_push && !buf_full;
  wire           do_read   = rx_valid && rx_ready;
  logic [EW-1:0] head;
  wire  [1:0]    next_count = count + 2'(do_write) - 2'(do_read);
  wire           next_rd    = rd_ptr ^ do_read;
  wire  [EW-1:0] push_word  = {rx_push_ferr, rx_push_perr, rx_shift};
  // Head is a flop for clean outputs; a word landing in the exposed slot bypasses it
  wire  [EW-1:0] next_head  = (do_write && wr_ptr == next_rd) ? push_word : slot[next_rd];

  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_ptr   <= 1'b0;
      wr_ptr   <= 1'b0;
      count    <= '0;
      head     <= '0;
      rx_valid <= 1'b0;
    end else begin
      if (do_write) wr_ptr <= ~wr_ptr;
      if (do_read) rd_ptr <= ~rd_ptr;
      count    <= next_count;
      head     <= next_head;
      rx_valid <= (next_count != 2'h0);
    end
  end
  genvar gi;
  for (gi = 0; gi < BUF_DEPTH; gi++) begin : g_slot
    always_ff @(posedge mclk) begin
      if (srst) slot[gi] <= '0;
      else if (do_write && wr_ptr == 1'(gi)) slot[gi] <= {rx_push_ferr, rx_push_perr, rx_shift};
    end
  end
  assign rx_data       = head[DATA_BITS-1:0];
  assign rx_parity_err = head[DATA_BITS];
  assign rx_frame_err  = head[DATA_BITS+1];
  // Throttle once any word waits: a second in flight still fits
  assign buf_space     = (count == 2'd0);
endmodule
`default_nettype wire

// ### verilog/serial_host_end.sv
`timescale 1ns/1ps
`default_nettype none
// Far end: sends on the device receive line, obeys request-to-send
module serial_host_end
  import serial_port_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 srst,
  serial_link_if.host               link,
  input  wire logic [DIV_W-1:0]     bit_div,
  input  wire logic                 parity_en,
  input  wire logic                 parity_odd,
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  input  wire logic [DATA_BITS-1:0] tx_data,
  output logic                      rx_valid,
  input  wire logic                 rx_ready,
  output logic [DATA_BITS-1:0]      rx_data,
  output logic                      rx_parity_err,
  output logic                      rx_frame_err
);
  logic rts_q;
  logic space;
  logic cts;
  always_ff @(posedge mclk) begin
    if (srst) begin
      rts_q <= HS_DEASSERT;
      cts   <= HS_DEASSERT;
    end else begin
      rts_q <= link.general_pin_five;
      cts   <= space ? HS_ASSERT : HS_DEASSERT;
    end
  end
  assign link.general_pin_seven = cts;

  serial_engine u_engine (
    .mclk          (mclk),
    .srst          (srst),
    .bit_div       (bit_div),
    .parity_en     (parity_en),
    .parity_odd    (parity_odd),
    .tx_allowed    (rts_q == HS_ASSERT),
    .tx_valid      (tx_valid),
    .tx_ready      (tx_ready),
    .tx_data       (tx_data),
    .tx_line       (link.general_pin_eight),
    .rx_line       (link.general_pin_six),
    .rx_valid      (rx_valid),
    .rx_ready      (rx_ready),
    .rx_data       (rx_data),
    .rx_parity_err (rx_parity_err),
    .rx_frame_err  (rx_frame_err),
    .buf_space     (space)
  );
endmodule
`default_nettype wire

// ### verilog/serial_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface serial_link_if;
  logic general_pin_six;    // Device transmit -> host receive
  logic general_pin_eight;  // Host transmit -> device receive
  logic general_pin_five;   // Device request-to-send, active low
  logic general_pin_seven;  // Device clear-to-send, active low
  modport device (
    output general_pin_six,
    input  general_pin_eight,
    output general_pin_five,
    input  general_pin_seven
  );
  modport host (
    input  general_pin_six,
    output general_pin_eight,
    input  general_pin_five,
    output general_pin_seven
  );
endinterface
`default_nettype wire

// ### verilog/serial_port_pkg.sv
`default_nettype none
package serial_port_pkg;
  // ******************************
  // Character framing
  // ******************************
  localparam int unsigned DATA_BITS    = 8;
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned MAX_BAUD     = 1_000_000;
  // Cycles per bit at the top rate; divisor is a port so slower rates work
  localparam int unsigned BIT_CYCLES   = CLK_HZ / MAX_BAUD;
  localparam int unsigned DIV_W        = 16;
  localparam logic [DIV_W-1:0] DIV_DEFAULT = DIV_W'(BIT_CYCLES);
  localparam int unsigned CNT_W        = 4;
  localparam logic [CNT_W-1:0] LAST_DATA = CNT_W'(DATA_BITS - 1);
  localparam logic START_LEVEL = 1'b0;
  localparam logic STOP_LEVEL  = 1'b1;
  localparam logic IDLE_LEVEL  = 1'b1;
  // Handshake lines are active low
  localparam logic HS_ASSERT   = 1'b0;
  localparam logic HS_DEASSERT = 1'b1;
  localparam int unsigned BUF_DEPTH = 2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP
  } frame_state_t;

  function automatic logic parity_of(input logic [DATA_BITS-1:0] d, input logic odd);
    parity_of = (^d) ^ odd;
  endfunction
endpackage
`default_nettype wire
